// [pkg/cafd_pkg.sv]
// Constants for the ADC flag and DAC output control register bank.
// Assumes an 8-bit register port with one-cycle strobes.
package cafd_pkg;
  localparam logic [7:0] OFS_FLAGS  = 8'h24;
  localparam logic [7:0] OFS_DACPWR = 8'h25;
  localparam logic [7:0] OFS_HPPROT = 8'h26;
  localparam logic [7:0] OFS_RSVD   = 8'h27;
  localparam logic [7:0] OFS_OSTAGE = 8'h28;
  localparam logic [7:0] OFS_DACSW  = 8'h29;
  localparam logic [7:0] OFS_IRQST  = 8'h30;
  localparam logic [7:0] OFS_IRQEN  = 8'h31;
  localparam logic [7:0] OFS_IRQCLR = 8'h32;
  localparam logic [7:0] RST_VAL    = 8'h00;
  // Writable bit masks; other bits are held at zero
  localparam logic [7:0] MSK_DACPWR = 8'hF0;
  localparam logic [7:0] MSK_HPPROT = 8'h06;
  localparam logic [7:0] MSK_OSTAGE = 8'hFF;
  localparam logic [7:0] MSK_DACSW  = 8'hF3;
  localparam int         IRQ_W      = 8;
  localparam logic [1:0] CODE_RSVD  = 2'h3;
  // Volume link codes
  localparam logic [1:0] LINK_L_FOLLOWS_R = 2'h1;
  localparam logic [1:0] LINK_R_FOLLOWS_L = 2'h2;
endpackage

// [src/cafd_edge.sv]
// Per-bit rise detector on the live flag vector.
// Assumes the flag inputs are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module cafd_edge #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] rise_o
);
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q_r <= '0;
    end else begin
      q_r <= d_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign rise_o[g] = d_i[g] & ~q_r[g];
    end
  endgenerate

  assign q_o = q_r;
endmodule
`default_nettype wire

// [src/cafd_regs.sv]
// Register bank: ADC/AGC flags, DAC power, output driver and switching control.
// Assumes a master with one-cycle strobes; read data valid the cycle after the strobe.
// How it works
// - Flag bits 7 and 3 read 1 when applied ADC gain equals programmed gain.
// - Flag bits 6 and 2 read 1 while matching ADC is powered up.
// - Flag bits 5 and 1 read 1 when signal power is below noise threshold.
// - Flag bits 4 and 0 read 1 when AGC applies maximum allowed gain.
// - DAC power bits 7 and 6 power left and right DACs; reset off.
// - Bits 5-4 configure common output driver: differential, constant, or single-ended.
// - Driver register bit 2 enables short-circuit protection on all drivers.
// - Bit 1 picks current limiting or automatic power-down on a short.
// - Output stage bits 7-6 pick common-mode level 1.35V to 1.8V.
// - Bits 5-4 select the left second-line bypass mode.
// - Bits 3-2 select the right second-line bypass mode.
// - Bits 1-0 set soft-stepping: per sample, per two samples, or immediate.
// - Switching bits 7-6 route the left DAC to path one, three or two.
// - Switching bits 5-4 route the right DAC to path one, three or two.
// - Bits 1-0 link DAC volumes: independent, left follows right, right follows left.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module cafd_regs (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Live ADC and AGC state, left then right
  input  wire logic [1:0] adc_gain_settled_i,
  input  wire logic [1:0] adc_powered_i,
  input  wire logic [1:0] agc_below_noise_i,
  input  wire logic [1:0] agc_at_max_gain_i,
  // Short detected on any high-power driver
  input  wire logic       short_detect_i,
  // DAC power and output configuration
  output logic            left_dac_power_o,
  output logic            right_dac_power_o,
  output logic      [1:0] common_output_driver_mode_o,
  output logic            short_protect_en_o,
  output logic            short_power_down_mode_o,
  output logic            driver_shutdown_o,
  output logic      [1:0] common_mode_level_sel_o,
  output logic      [1:0] left_second_line_bypass_o,
  output logic      [1:0] right_second_line_bypass_o,
  output logic      [1:0] soft_step_mode_o,
  output logic      [1:0] left_dac_route_o,
  output logic      [1:0] right_dac_route_o,
  output logic            left_vol_follows_right_o,
  output logic            right_vol_follows_left_o,
  // Interrupt
  output logic            irq_o
);
  logic [7:0] flags_live;
  logic [7:0] flags_r;
  logic [7:0] flag_rise;
  logic [7:0] dacpwr_r;
  logic [7:0] hpprot_r;
  logic [7:0] ostage_r;
  logic [7:0] dacsw_r;
  logic [7:0] irq_st_r;
  logic [7:0] irq_en_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] irq_set;
  logic       shut_r;
  logic       irq_r;
  logic [7:0] out_a_r;
  logic [7:0] out_b_r;
  logic [7:0] out_c_r;

  assign flags_live = {adc_gain_settled_i[1], adc_powered_i[1],
                       agc_below_noise_i[1], agc_at_max_gain_i[1],
                       adc_gain_settled_i[0], adc_powered_i[0],
                       agc_below_noise_i[0], agc_at_max_gain_i[0]};

  // Registered copy of the flags plus rise events for the interrupt
  cafd_edge #(.W(8)) u_edge (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (flags_live),
    .q_o     (flags_r),
    .rise_o  (flag_rise)
  );

  // Control register writes; reserved bits masked to zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dacpwr_r <= cafd_pkg::RST_VAL;
      hpprot_r <= cafd_pkg::RST_VAL;
      ostage_r <= cafd_pkg::RST_VAL;
      dacsw_r  <= cafd_pkg::RST_VAL;
    end else if (wr_i) begin
      unique case (addr_i)
        cafd_pkg::OFS_DACPWR: begin
          dacpwr_r <= wdata_i & cafd_pkg::MSK_DACPWR;
        end
        cafd_pkg::OFS_HPPROT: begin
          hpprot_r <= wdata_i & cafd_pkg::MSK_HPPROT;
        end
        cafd_pkg::OFS_OSTAGE: begin
          ostage_r <= wdata_i & cafd_pkg::MSK_OSTAGE;
        end
        cafd_pkg::OFS_DACSW: begin
          dacsw_r <= wdata_i & cafd_pkg::MSK_DACSW;
        end
        default: begin
          // Flag and reserved registers ignore writes
        end
      endcase
    end
  end

  // Interrupt enable
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_en_r <= cafd_pkg::RST_VAL;
    end else if (wr_i && addr_i == cafd_pkg::OFS_IRQEN) begin
      irq_en_r <= wdata_i;
    end
  end

  // Sticky status: a flag rising sets its bit; set wins over a same-cycle clear
  assign irq_set = flag_rise;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_st_r <= cafd_pkg::RST_VAL;
    end else if (wr_i && addr_i == cafd_pkg::OFS_IRQCLR) begin
      irq_st_r <= (irq_st_r & ~wdata_i) | irq_set;
    end else begin
      irq_st_r <= irq_st_r | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |((irq_st_r | irq_set) & irq_en_r);
    end
  end

  // Automatic driver power-down latches on a short until protection or power-down mode
  // is turned off; a latched shutdown avoids re-driving into a persistent short.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shut_r <= 1'b0;
    end else if (!hpprot_r[2] || !hpprot_r[1]) begin
      shut_r <= 1'b0;
    end else if (short_detect_i) begin
      shut_r <= 1'b1;
    end
  end

  // Read mux; reads change no state
  always_comb begin
    rdata_nxt = cafd_pkg::RST_VAL;
    unique case (addr_i)
      cafd_pkg::OFS_FLAGS:  rdata_nxt = flags_live;
      cafd_pkg::OFS_DACPWR: rdata_nxt = dacpwr_r;
      cafd_pkg::OFS_HPPROT: rdata_nxt = hpprot_r;
      cafd_pkg::OFS_RSVD:   rdata_nxt = cafd_pkg::RST_VAL;
      cafd_pkg::OFS_OSTAGE: rdata_nxt = ostage_r;
      cafd_pkg::OFS_DACSW:  rdata_nxt = dacsw_r;
      cafd_pkg::OFS_IRQST:  rdata_nxt = irq_st_r;
      cafd_pkg::OFS_IRQEN:  rdata_nxt = irq_en_r;
      default:              rdata_nxt = cafd_pkg::RST_VAL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= cafd_pkg::RST_VAL;
    end else if (rd_i) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= cafd_pkg::RST_VAL;
    end
  end

  // Output flops, one per field group
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_a_r <= cafd_pkg::RST_VAL;
      out_b_r <= cafd_pkg::RST_VAL;
      out_c_r <= cafd_pkg::RST_VAL;
    end else begin
      out_a_r <= dacpwr_r;
      out_b_r <= ostage_r;
      out_c_r <= dacsw_r;
    end
  end

  // Protection outputs are registered separately from the shutdown latch
  logic [2:0] prot_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prot_r <= 3'h0;
    end else begin
      // Gate with the live mode bits so shutdown drops in the same cycle as protection
      prot_r <= {hpprot_r[2], hpprot_r[1], shut_r & hpprot_r[2] & hpprot_r[1]};
    end
  end

  assign rdata_o                     = rdata_r;
  assign left_dac_power_o            = out_a_r[7];
  assign right_dac_power_o           = out_a_r[6];
  assign common_output_driver_mode_o = out_a_r[5:4];
  assign short_protect_en_o          = prot_r[2];
  assign short_power_down_mode_o     = prot_r[1];
  assign driver_shutdown_o           = prot_r[0];
  assign common_mode_level_sel_o     = out_b_r[7:6];
  assign left_second_line_bypass_o   = out_b_r[5:4];
  assign right_second_line_bypass_o  = out_b_r[3:2];
  assign soft_step_mode_o            = out_b_r[1:0];
  assign left_dac_route_o            = out_c_r[7:6];
  assign right_dac_route_o           = out_c_r[5:4];
  assign irq_o                       = irq_r;

  // Link decode registered; codes 00 and 11 both mean independent
  logic [1:0] link_r;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      link_r <= 2'h0;
    end else begin
      link_r[1] <= (dacsw_r[1:0] == cafd_pkg::LINK_L_FOLLOWS_R);
      link_r[0] <= (dacsw_r[1:0] == cafd_pkg::LINK_R_FOLLOWS_L);
    end
  end
  assign left_vol_follows_right_o = link_r[1];
  assign right_vol_follows_left_o = link_r[0];

  // Assertions on the read port
  a_flag_read_live: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_FLAGS |=> rdata_o == $past(flags_live))
    else $error("flag read does not match live state");
  a_gain_bit_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_FLAGS
      |=> rdata_o[7] == $past(adc_gain_settled_i[1])
          && rdata_o[3] == $past(adc_gain_settled_i[0]))
    else $error("gain settled flags misplaced");
  a_power_bit_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_FLAGS
      |=> rdata_o[6] == $past(adc_powered_i[1])
          && rdata_o[2] == $past(adc_powered_i[0]))
    else $error("ADC power flags misplaced");
  a_noise_bit_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_FLAGS
      |=> rdata_o[5] == $past(agc_below_noise_i[1])
          && rdata_o[1] == $past(agc_below_noise_i[0]))
    else $error("noise flags misplaced");
  a_sat_bit_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_FLAGS
      |=> rdata_o[4] == $past(agc_at_max_gain_i[1])
          && rdata_o[0] == $past(agc_at_max_gain_i[0]))
    else $error("saturation flags misplaced");
  a_read_no_effect: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && !wr_i
      |=> {dacpwr_r, hpprot_r, ostage_r, dacsw_r, irq_en_r}
          == $past({dacpwr_r, hpprot_r, ostage_r, dacsw_r, irq_en_r})
          && ($past(irq_st_r) & ~irq_st_r) == 8'h00)
    else $error("read changed register state");
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not cleared after the read cycle");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_RSVD |=> rdata_o == 8'h00)
    else $error("reserved register read nonzero");
  a_pwr_rsvd_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_DACPWR |=> rdata_o[3:0] == 4'h0)
    else $error("DAC power reserved bits nonzero");
  a_prot_rsvd_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_HPPROT
      |=> rdata_o[7:3] == 5'h00 && rdata_o[0] == 1'h0)
    else $error("driver protection reserved bits nonzero");
  a_sw_rsvd_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_i && addr_i == cafd_pkg::OFS_DACSW |=> rdata_o[3:2] == 2'h0)
    else $error("switching reserved bits nonzero");
  // Assertions on the control outputs
  a_dac_power_out: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_DACPWR
      |=> ##1 left_dac_power_o == $past(wdata_i[7], 2)
          && right_dac_power_o == $past(wdata_i[6], 2))
    else $error("DAC power output wrong after write");
  a_common_drv_mode: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_DACPWR
      |=> ##1 common_output_driver_mode_o == $past(wdata_i[5:4], 2))
    else $error("common driver mode wrong");
  a_protect_out: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_HPPROT
      |=> ##1 short_protect_en_o == $past(wdata_i[2], 2)
          && short_power_down_mode_o == $past(wdata_i[1], 2))
    else $error("protection outputs wrong after write");
  a_shut_needs_mode: assert property (@(posedge clk_i) disable iff (reset_i)
    driver_shutdown_o |-> short_protect_en_o && short_power_down_mode_o)
    else $error("shutdown without power-down protection");
  // A write that turns protection off in the same cycle rightly cancels the shutdown
  a_short_shutdown: assert property (@(posedge clk_i) disable iff (reset_i)
    short_detect_i && hpprot_r[2] && hpprot_r[1]
      && !(wr_i && addr_i == cafd_pkg::OFS_HPPROT) |-> ##2 driver_shutdown_o)
    else $error("short did not shut down driver");
  a_stage_fields: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_OSTAGE
      |=> ##1 {common_mode_level_sel_o, left_second_line_bypass_o,
               right_second_line_bypass_o, soft_step_mode_o} == $past(wdata_i, 2))
    else $error("output stage fields wrong");
  a_left_bypass: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_OSTAGE
      |=> ##1 left_second_line_bypass_o == $past(wdata_i[5:4], 2))
    else $error("left bypass field wrong");
  a_right_bypass: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_OSTAGE
      |=> ##1 right_second_line_bypass_o == $past(wdata_i[3:2], 2))
    else $error("right bypass field wrong");
  a_soft_step: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_OSTAGE
      |=> ##1 soft_step_mode_o == $past(wdata_i[1:0], 2))
    else $error("soft-stepping field wrong");
  a_route_fields: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_DACSW
      |=> ##1 left_dac_route_o == $past(wdata_i[7:6], 2)
          && right_dac_route_o == $past(wdata_i[5:4], 2))
    else $error("DAC route fields wrong");
  a_right_route: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_DACSW
      |=> ##1 right_dac_route_o == $past(wdata_i[5:4], 2))
    else $error("right DAC route wrong");
  a_link_decode: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_DACSW
      |=> ##1
        left_vol_follows_right_o == ($past(wdata_i[1:0], 2) == cafd_pkg::LINK_L_FOLLOWS_R)
        && right_vol_follows_left_o == ($past(wdata_i[1:0], 2) == cafd_pkg::LINK_R_FOLLOWS_L))
    else $error("volume link decode wrong");
  a_link_exclusive: assert property (@(posedge clk_i) disable iff (reset_i)
    !(left_vol_follows_right_o && right_vol_follows_left_o))
    else $error("both volume links active");
  // Assertions on the interrupt path
  a_irq_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    (flags_live & ~flags_r) != 8'h00
      |=> (irq_st_r & $past(flags_live & ~flags_r)) == $past(flags_live & ~flags_r))
    else $error("flag event lost");
  a_irq_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == cafd_pkg::OFS_IRQCLR && wdata_i[0] && !flag_rise[0] |=> !irq_st_r[0])
    else $error("status bit not cleared");
  a_irq_masked: assert property (@(posedge clk_i) disable iff (reset_i)
    irq_en_r == 8'h00 |=> !irq_o)
    else $error("interrupt raised while masked");
  a_irq_raised: assert property (@(posedge clk_i) disable iff (reset_i)
    (irq_st_r & irq_en_r) != 8'h00 |=> irq_o)
    else $error("enabled status did not raise interrupt");
endmodule
`default_nettype wire

// [test/codec_adc_flag_dac_output_ctrl_bench.sv]
// Self-checking bench for the ADC flag and DAC output control register bank.
// Assumes one 100 MHz clock and the one-cycle strobe register port of cafd_regs.
`timescale 1ns/1ps
`default_nettype none
module codec_adc_flag_dac_output_ctrl_bench;
  logic       clk_i;
  logic       reset_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic [1:0] gset, gpow, gnoise, gmax;
  logic       short_i;
  logic       lpow, rpow, prot, pdm, shut, lfr, rfl, irq;
  logic [1:0] cod, cml, lbp, rbp, ss, lrt, rrt;
  logic [1:0] c2, r2;
  logic [7:0] v, d;
  int         err_total;
  int         compares;

  cafd_regs u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_gain_settled_i(gset),
    .adc_powered_i(gpow), .agc_below_noise_i(gnoise), .agc_at_max_gain_i(gmax),
    .short_detect_i(short_i), .left_dac_power_o(lpow), .right_dac_power_o(rpow),
    .common_output_driver_mode_o(cod), .short_protect_en_o(prot),
    .short_power_down_mode_o(pdm), .driver_shutdown_o(shut),
    .common_mode_level_sel_o(cml), .left_second_line_bypass_o(lbp),
    .right_second_line_bypass_o(rbp), .soft_step_mode_o(ss), .left_dac_route_o(lrt),
    .right_dac_route_o(rrt), .left_vol_follows_right_o(lfr),
    .right_vol_follows_left_o(rfl), .irq_o(irq)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Each access starts on a fresh edge, so strobes are never assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= dv;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] dv);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #2;
    dv = rdata_o;
  endtask

  // Outputs lag a write by two edges; three leaves margin
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic flags(input logic [7:0] f);
    @(posedge clk_i);
    gset   <= {f[7], f[3]};
    gpow   <= {f[6], f[2]};
    gnoise <= {f[5], f[1]};
    gmax   <= {f[4], f[0]};
    settle();
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    conclude();
  end

  initial begin
    err_total = 0;
    compares  = 0;
    reset_i   = 1'b1;
    addr_i    = 8'h00;
    wdata_i   = 8'h00;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    gset      = 2'h0;
    gpow      = 2'h0;
    gnoise    = 2'h0;
    gmax      = 2'h0;
    short_i   = 1'b0;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    settle();
    check("outputs at reset", {lpow, rpow, prot, pdm, shut, lfr, rfl, irq}, 8'h00);
    check("fields at reset", {cod, cml, lbp, rbp}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd((i < 6) ? 8'(8'h24 + i) : 8'(8'h2A + i), v);
      check("reset value", v, 8'h00);
    end
    rd(8'h50, v);
    check("unmapped read", v, 8'h00);
    // Walk one live flag at a time; each read twice shows reads leave it alone
    for (int b = 0; b < 8; b++) begin
      flags(8'(8'h01 << b));
      rd(8'h24, v);
      check("flag bit", v, 8'(8'h01 << b));
      rd(8'h24, v);
      check("flag reread", v, 8'(8'h01 << b));
    end
    wr(8'h24, 8'hFF);
    rd(8'h24, v);
    check("flags after write", v, 8'h80);
    rd(8'h30, v);
    check("irq status", v, 8'hFF);
    wr(8'h32, 8'hFF);
    flags(8'h00);
    wr(8'h31, 8'h01);
    rd(8'h30, v);
    check("status cleared", v, 8'h00);
    check("irq idle", {7'h00, irq}, 8'h00);
    flags(8'h01);
    rd(8'h31, v);
    check("irq enable", v, 8'h01);
    check("irq raised", {7'h00, irq}, 8'h01);
    wr(8'h31, 8'h00);
    settle();
    check("irq masked", {7'h00, irq}, 8'h00);
    wr(8'h31, 8'h01);
    settle();
    check("irq unmasked", {7'h00, irq}, 8'h01);
    wr(8'h32, 8'h01);
    settle();
    check("irq cleared", {7'h00, irq}, 8'h00);
    // DAC power and common driver modes; reserved code and bits left at zero
    for (int i = 0; i < 4; i++) begin
      c2 = 2'(i);
      d  = {c2, (i == 3) ? 2'h0 : c2, 4'h0};
      wr(8'h25, d);
      settle();
      rd(8'h25, v);
      check("dac power reg", v, d);
      check("dac power out", {4'h0, lpow, rpow, cod}, {4'h0, d[7:4]});
    end
    @(posedge clk_i);
    short_i <= 1'b1;
    wr(8'h26, 8'h04);
    settle();
    rd(8'h26, v);
    check("protect reg", v, 8'h04);
    check("current limit", {5'h00, prot, pdm, shut}, 8'h04);
    wr(8'h26, 8'h06);
    settle();
    check("auto power down", {5'h00, prot, pdm, shut}, 8'h07);
    wr(8'h26, 8'h02);
    settle();
    check("protect off", {5'h00, prot, pdm, shut}, 8'h02);
    @(posedge clk_i);
    short_i <= 1'b0;
    wr(8'h26, 8'h00);
    // Every code of the output stage and switching fields, reserved ones excepted
    for (int i = 0; i < 4; i++) begin
      c2 = 2'(i);
      r2 = (i == 3) ? 2'h2 : c2;
      d  = {c2, c2, c2, r2};
      wr(8'h28, d);
      settle();
      rd(8'h28, v);
      check("stage reg", v, d);
      check("stage out", {cml, lbp, rbp, ss}, d);
      d = {r2, r2, 2'h0, c2};
      wr(8'h29, d);
      settle();
      rd(8'h29, v);
      check("switch reg", v, d);
      check("route out", {lrt, rrt, 4'h0}, {r2, r2, 4'h0});
      check("volume link", {6'h00, lfr, rfl}, {6'h00, c2 == 2'h1, c2 == 2'h2});
    end
    wr(8'h50, 8'hFF);
    rd(8'h50, v);
    check("unmapped write", v, 8'h00);
    // Reset in mid-run must drop the DAC power, output stage and switching registers back to their defaults
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    settle();
    check("outputs after reset", {lpow, rpow, cod, lfr, rfl, irq, 1'b0}, 8'h00);
    check("fields after reset", {cml, lbp, rbp, ss}, 8'h00);
    check("routes after reset", {lrt, rrt, 4'h0}, 8'h00);
    rd(8'h29, v);
    check("switch reg after reset", v, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
